// ### verilog/amfs_pkg.sv
// amfs_pkg: offsets, reset values and carriers of the fault/status bank
// assumes one control-port clock domain and 8-bit registers
package amfs_pkg;
   // register offsets
   localparam logic [7:0] AMFS_ADDR_CTRL = 8'h01; // run bit and bridge mode
   localparam logic [7:0] AMFS_ADDR_CHSEL = 8'h06; // mono source select
   localparam logic [7:0] AMFS_ADDR_RSVD = 8'h07; // reserved slot
   localparam logic [7:0] AMFS_ADDR_FAULT = 8'h08; // fault config and status
   // field positions
   localparam int AMFS_CTRL_RUN = 0; // 0 forces shutdown
   localparam int AMFS_CTRL_BRIDGE = 1; // parallel bridge mode
   localparam int AMFS_CHSEL_MONO = 1; // 1 left, 0 right
   localparam int AMFS_FLT_SCALE_LO = 4; // limit scale 5:4
   localparam int AMFS_FLT_CLK = 3;
   localparam int AMFS_FLT_OC = 2;
   localparam int AMFS_FLT_DC = 1;
   localparam int AMFS_FLT_OT = 0;
   // values after reset
   localparam logic [7:0] AMFS_CTRL_RST = 8'h01;
   localparam logic [7:0] AMFS_CHSEL_RST = 8'h01; // reserved bit 0 is 1
   localparam logic [1:0] AMFS_SCALE_RST = 2'h0;
   localparam logic [1:0] AMFS_RSVD_FLT = 2'h0; // fault bits 7:6
   // limit scale codes
   localparam logic [1:0] AMFS_SCALE_75 = 2'h1;
   localparam logic [1:0] AMFS_SCALE_50 = 2'h2;
   localparam logic [1:0] AMFS_SCALE_25 = 2'h3;
   // decoded control-port access
   typedef struct packed {
      logic wr; // write strobe
      logic rd; // read strobe
      logic [7:0] addr; // register offset
      logic [7:0] wdata; // write data
   } amfs_req_t;
   // raw fault levels from the analog side
   typedef struct packed {
      logic clk_err; // clock error level
      logic dc_err; // dc offset over limit
      logic ot_err; // die over temperature
   } amfs_det_t;
endpackage

// ### verilog/amfs_bank.sv
// amfs_bank: fault configuration, error flags and mono source routing
// assumes a control-port engine gives decoded strobes on clk_sys_i;
// fault levels and the shutdown pin are asynchronous
//
// How it works
// - mono select 1 in bridge mode: left
// - mono select 0 in bridge mode: right
// - fault bits 7:6 read zero; other reserved bits take written data
// - limit scale 00 full, 75, 50, 25 percent
// - clock flag follows clock error, never latches
// - overcurrent flag set above scaled limit
// - overcurrent latches, halts until shutdown toggles
// - dc offset latches, halts until shutdown toggles
// - overtemperature latches, halts until shutdown toggles
// - fault flags read-only, reset to zero
// - shutdown by pin low or run bit clear
module amfs_bank import amfs_pkg::*; #(
   parameter int OCW = 10, // width of the current measure
   parameter logic [OCW-1:0] OC_NOMINAL = 10'h300, // full-scale trip level
   parameter int DW = 24 // audio sample width
) (
   input wire logic clk_sys_i, // system clock, 10 MHz
   input wire logic reset_i, // synchronous reset, high
   input wire amfs_req_t req_i, // decoded register access
   output logic [7:0] rdata_o, // read data
   output logic rvalid_o, // read data valid pulse
   input wire amfs_det_t det_i, // async fault levels
   input wire logic [OCW-1:0] oc_level_i, // async output current measure
   input wire logic amp_shutdown_n_i, // async shutdown pin, low stops
   input wire logic sample_valid_i, // audio sample strobe
   input wire logic [DW-1:0] left_i, // left input sample
   input wire logic [DW-1:0] right_i, // right input sample
   output logic [DW-1:0] spk_a_o, // first speaker channel
   output logic [DW-1:0] spk_b_o, // second speaker channel
   output logic amp_run_o // amplifier in normal operation
);
   localparam int SW = OCW + 4; // synchronised bits

   // scaled trip level for a scale code
   function automatic logic [OCW-1:0] oc_thr(input logic [1:0] code);
      unique case (code)
         AMFS_SCALE_75: oc_thr = OC_NOMINAL - (OC_NOMINAL >> 2);
         AMFS_SCALE_50: oc_thr = OC_NOMINAL >> 1;
         AMFS_SCALE_25: oc_thr = OC_NOMINAL >> 2;
         default: oc_thr = OC_NOMINAL;
      endcase
   endfunction

   logic [SW-1:0] meta_ff; // first synchroniser stage
   logic [SW-1:0] sync_ff; // second synchroniser stage
   logic clk_s, dc_s, ot_s, pin_s; // synchronised levels
   logic [OCW-1:0] oc_s; // synchronised current measure

   // two-flop synchroniser for every async input
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= {det_i.clk_err, det_i.dc_err, det_i.ot_err, amp_shutdown_n_i,
            oc_level_i};
         sync_ff <= meta_ff;
      end
   end
   assign {clk_s, dc_s, ot_s, pin_s, oc_s} = sync_ff;

   logic [7:0] ctrl_ff, nxt_ctrl; // run and bridge mode
   logic [7:0] chsel_ff, nxt_chsel; // mono select and reserved bit
   logic [1:0] overcurrent_limit_scale_ff, nxt_overcurrent_limit_scale; // trip level scale code
   logic clock_fault_flag_ff, nxt_clock_fault_flag;
   logic overcurrent_fault_flag_ff, nxt_overcurrent_fault_flag;
   logic dc_offset_fault_flag_ff, nxt_dc_offset_fault_flag;
   logic overtemp_fault_flag_ff, nxt_overtemp_fault_flag;
   logic shut_q_ff, nxt_shut_q; // previous shutdown state
   logic [7:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;
   logic run_ff, nxt_run;
   logic [DW-1:0] spk_a_ff, nxt_spk_a, spk_b_ff, nxt_spk_b;
   logic shut, clear_evt, oc_over, halt, parallel_bridge_mode, mono_source_select;

   // shutdown request and its entry edge
   always_comb begin
      shut = !pin_s || !ctrl_ff[AMFS_CTRL_RUN];
      clear_evt = shut && !shut_q_ff;
      oc_over = oc_s > oc_thr(overcurrent_limit_scale_ff);
      parallel_bridge_mode = ctrl_ff[AMFS_CTRL_BRIDGE];
      mono_source_select = chsel_ff[AMFS_CHSEL_MONO];
   end

   // configuration writes; reserved slot and flag bits ignore writes
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_chsel = chsel_ff;
      nxt_overcurrent_limit_scale = overcurrent_limit_scale_ff;
      if (req_i.wr) begin
         unique case (req_i.addr)
            AMFS_ADDR_CTRL: nxt_ctrl = req_i.wdata;
            AMFS_ADDR_CHSEL: nxt_chsel = req_i.wdata;
            AMFS_ADDR_FAULT: begin
               nxt_overcurrent_limit_scale = req_i.wdata[AMFS_FLT_SCALE_LO +: 2];
            end
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
   end

   // fault flags: latched ones clear on shutdown entry, set wins
   always_comb begin
      nxt_clock_fault_flag = clk_s;
      nxt_overcurrent_fault_flag = oc_over || (overcurrent_fault_flag_ff && !clear_evt);
      nxt_dc_offset_fault_flag = dc_s || (dc_offset_fault_flag_ff && !clear_evt);
      nxt_overtemp_fault_flag = ot_s || (overtemp_fault_flag_ff && !clear_evt);
      nxt_shut_q = shut;
   end

   // read path has no side effect on any flag
   always_comb begin
      nxt_rvalid = req_i.rd;
      nxt_rdata = rdata_ff;
      if (req_i.rd) begin
         unique case (req_i.addr)
            AMFS_ADDR_CTRL: nxt_rdata = ctrl_ff;
            AMFS_ADDR_CHSEL: nxt_rdata = chsel_ff;
            AMFS_ADDR_FAULT: nxt_rdata = {AMFS_RSVD_FLT, overcurrent_limit_scale_ff,
               clock_fault_flag_ff, overcurrent_fault_flag_ff, dc_offset_fault_flag_ff,
               overtemp_fault_flag_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // run state and speaker routing
   always_comb begin
      halt = clock_fault_flag_ff || overcurrent_fault_flag_ff || dc_offset_fault_flag_ff
         || overtemp_fault_flag_ff;
      nxt_run = !shut && !halt;
      nxt_spk_a = spk_a_ff;
      nxt_spk_b = spk_b_ff;
      if (!run_ff) begin
         nxt_spk_a = '0; // muted while halted
         nxt_spk_b = '0;
      end else if (sample_valid_i) begin
         if (parallel_bridge_mode) begin
            nxt_spk_a = mono_source_select ? left_i : right_i;
            nxt_spk_b = mono_source_select ? left_i : right_i;
         end else begin
            nxt_spk_a = left_i; // stereo
            nxt_spk_b = right_i;
         end
      end
   end

   // state registers
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ctrl_ff <= AMFS_CTRL_RST;
         chsel_ff <= AMFS_CHSEL_RST;
         overcurrent_limit_scale_ff <= AMFS_SCALE_RST;
         clock_fault_flag_ff <= 1'b0;
         overcurrent_fault_flag_ff <= 1'b0;
         dc_offset_fault_flag_ff <= 1'b0;
         overtemp_fault_flag_ff <= 1'b0;
         shut_q_ff <= 1'b1;
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
         run_ff <= 1'b0;
         spk_a_ff <= '0;
         spk_b_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         chsel_ff <= nxt_chsel;
         overcurrent_limit_scale_ff <= nxt_overcurrent_limit_scale;
         clock_fault_flag_ff <= nxt_clock_fault_flag;
         overcurrent_fault_flag_ff <= nxt_overcurrent_fault_flag;
         dc_offset_fault_flag_ff <= nxt_dc_offset_fault_flag;
         overtemp_fault_flag_ff <= nxt_overtemp_fault_flag;
         shut_q_ff <= nxt_shut_q;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         run_ff <= nxt_run;
         spk_a_ff <= nxt_spk_a;
         spk_b_ff <= nxt_spk_b;
      end
   end

   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;
   assign amp_run_o = run_ff;
   assign spk_a_o = spk_a_ff;
   assign spk_b_o = spk_b_ff;

   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   property p_left_src;
      run_ff && parallel_bridge_mode && mono_source_select && sample_valid_i
         |=> spk_a_o == $past(left_i) && spk_b_o == $past(left_i);
   endproperty
   a_left_src: assert property (p_left_src) else $error("bridge left not routed");

   property p_right_src;
      run_ff && parallel_bridge_mode && !mono_source_select && sample_valid_i
         |=> spk_a_o == $past(right_i) && spk_b_o == $past(right_i);
   endproperty
   a_right_src: assert property (p_right_src) else $error("bridge right not routed");

   property p_rsvd_zero;
      req_i.rd && req_i.addr == AMFS_ADDR_FAULT |=> rvalid_o && rdata_o[7:6] == 2'h0
         && rdata_o[5:4] == $past(overcurrent_limit_scale_ff);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("fault read wrong");

   property p_scale_trip;
      overcurrent_limit_scale_ff == AMFS_SCALE_50 && oc_s > (OC_NOMINAL >> 1)
         |=> overcurrent_fault_flag_ff;
   endproperty
   a_scale_trip: assert property (p_scale_trip) else $error("half limit missed");

   property p_clk_follow;
      !clk_s |=> !clock_fault_flag_ff;
   endproperty
   a_clk_follow: assert property (p_clk_follow) else $error("clock flag stuck");

   // run comes back on its own once clocks are good and nothing else blocks it
   property p_clk_resume;
      !clk_s ##1 (!shut && !halt) |=> amp_run_o;
   endproperty
   a_clk_resume: assert property (p_clk_resume) else $error("run not resumed");

   property p_oc_quiet;
      !overcurrent_fault_flag_ff && !oc_over |=> !overcurrent_fault_flag_ff;
   endproperty
   a_oc_quiet: assert property (p_oc_quiet) else $error("spurious overcurrent");

   property p_oc_hold;
      overcurrent_fault_flag_ff && !clear_evt |=> overcurrent_fault_flag_ff && !amp_run_o;
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("overcurrent lost");

   property p_dc_hold;
      dc_offset_fault_flag_ff && !clear_evt |=> dc_offset_fault_flag_ff ##1 !amp_run_o;
   endproperty
   a_dc_hold: assert property (p_dc_hold) else $error("dc flag lost");

   property p_ot_clear;
      clear_evt && !ot_s |=> !overtemp_fault_flag_ff;
   endproperty
   a_ot_clear: assert property (p_ot_clear) else $error("overtemp not cleared");

   property p_read_keeps;
      req_i.rd && overtemp_fault_flag_ff && !clear_evt |=> overtemp_fault_flag_ff;
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read cleared flag");
endmodule

// ### sim/amfs_host.sv
// amfs_host: control-port master model for the fault/status bank
// assumes clk_sys_i from the bench; strobes move 1 ns after edges
module amfs_host import amfs_pkg::*; (
   input wire logic clk_sys_i, // system clock
   output amfs_req_t req_o, // decoded access to the bank
   input wire logic [7:0] rdata_i, // read data
   input wire logic rvalid_i // read data valid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req_o = '0;
   // one write strobe taken at a single edge, then released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == AMFS_ADDR_RSVD) return;
      @(posedge clk_sys_i);
      #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys_i);
      #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // one read strobe; data is taken while its valid pulse stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'h00;
      if (a == AMFS_ADDR_RSVD) return;
      @(posedge clk_sys_i);
      #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys_i);
      #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      d = rvalid_i ? rdata_i : 8'hXX;
   endtask
endmodule

// ### sim/tb_amp_fault_status_config.sv
// tb_amp_fault_status_config: scenario bench for the fault/status bank
// assumes amfs_bank and the host model; fault inputs held steady
module tb_amp_fault_status_config import amfs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [9:0] NOM = 10'h300; // full-scale trip level
   logic clk_sys_i, reset_i, rvalid, sd_n, sv, run;
   amfs_req_t req; // host strobes
   amfs_det_t det; // fault levels
   logic [7:0] rdata;
   logic [9:0] oc; // current measure
   logic [23:0] left, right, spk_a, spk_b;
   int n_errors, n_checks;
   amfs_bank #(.OCW(10), .OC_NOMINAL(NOM), .DW(24)) i_amfs_bank (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .det_i(det),
      .oc_level_i(oc), .amp_shutdown_n_i(sd_n), .sample_valid_i(sv), .left_i(left),
      .right_i(right), .spk_a_o(spk_a), .spk_b_o(spk_b), .amp_run_o(run));
   amfs_host i_amfs_host (.clk_sys_i(clk_sys_i), .req_o(req), .rdata_i(rdata),
      .rvalid_i(rvalid));
   // clock at 100 ns period
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   // wait whole cycles, land 1 ns past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_amfs_host.rd(a, d);
      chk("read data", {16'h0000, e}, {16'h0000, d});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic t_reset;
      rchk(AMFS_ADDR_FAULT, 8'h00);
      rchk(AMFS_ADDR_CHSEL, AMFS_CHSEL_RST);
      rchk(8'h20, 8'h00); // unmapped reads zero
      chk("run", 24'h1, {23'h0, run});
      $display("test reset done");
   endtask
   // each limit code: at the limit no flag, one above latches until shutdown
   task automatic t_scale;
      logic [9:0] thr;
      logic [7:0] f;
      i_amfs_host.wr(AMFS_ADDR_FAULT, 8'h3F);
      rchk(AMFS_ADDR_FAULT, 8'h30);
      for (int c = 0; c < 4; c++) begin
         thr = (c == 0) ? NOM : (c == 1) ? NOM - (NOM >> 2) : (c == 2) ? NOM >> 1 : NOM >> 2;
         f = {2'h0, c[1:0], 4'h0};
         i_amfs_host.wr(AMFS_ADDR_FAULT, f);
         oc = thr;
         cyc(6);
         rchk(AMFS_ADDR_FAULT, f);
         oc = thr + 10'h001;
         cyc(6);
         chk("run", 24'h0, {23'h0, run});
         oc = 10'h000;
         cyc(6);
         rchk(AMFS_ADDR_FAULT, f | 8'h04);
         sd_n = 1'b0;
         cyc(6);
         sd_n = 1'b1;
         cyc(8);
         rchk(AMFS_ADDR_FAULT, f);
         chk("run", 24'h1, {23'h0, run});
      end
      i_amfs_host.wr(AMFS_ADDR_FAULT, 8'h00);
      $display("test scale done");
   endtask
   task automatic t_latch;
      det = '{clk_err: 1'b0, dc_err: 1'b1, ot_err: 1'b1};
      cyc(6);
      det = '0;
      cyc(6);
      rchk(AMFS_ADDR_FAULT, 8'h03);
      rchk(AMFS_ADDR_FAULT, 8'h03);
      chk("run", 24'h0, {23'h0, run});
      i_amfs_host.wr(AMFS_ADDR_CTRL, 8'h00);
      cyc(6);
      i_amfs_host.wr(AMFS_ADDR_CTRL, AMFS_CTRL_RST);
      cyc(6);
      rchk(AMFS_ADDR_FAULT, 8'h00);
      det.clk_err = 1'b1;
      cyc(6);
      rchk(AMFS_ADDR_FAULT, 8'h08);
      det.clk_err = 1'b0;
      cyc(6);
      rchk(AMFS_ADDR_FAULT, 8'h00);
      chk("run", 24'h1, {23'h0, run});
      $display("test latch done");
   endtask
   // bridge mode: both outputs carry the selected channel
   task automatic t_mono;
      i_amfs_host.wr(AMFS_ADDR_CTRL, 8'h03);
      for (int s = 1; s >= 0; s--) begin
         i_amfs_host.wr(AMFS_ADDR_CHSEL, {6'h00, s[0], 1'b1});
         sv = 1'b1;
         cyc(1);
         sv = 1'b0;
         chk("spk a", s ? left : right, spk_a);
         chk("spk b", s ? left : right, spk_b);
      end
      // bridge off: each output keeps its own channel
      i_amfs_host.wr(AMFS_ADDR_CTRL, AMFS_CTRL_RST);
      sv = 1'b1;
      cyc(1);
      sv = 1'b0;
      chk("spk a", left, spk_a); // stereo path
      chk("spk b", right, spk_b); // stereo path
      $display("test mono done");
   endtask
   initial begin
      reset_i = 1'b1;
      det = '0;
      oc = 10'h000;
      sd_n = 1'b1;
      sv = 1'b0;
      left = 24'h123456;
      right = 24'hABCDEF;
      n_errors = 0;
      n_checks = 0;
      repeat (8) @(posedge clk_sys_i);
      #1 reset_i = 1'b0;
      t_reset;
      t_scale;
      t_latch;
      t_mono;
      test_done;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_errors++;
      test_done;
   end
endmodule
